// *** pwm_tb_cfg.svh ***
`ifndef PWM_TB_CFG_SVH
`define PWM_TB_CFG_SVH

// Register offsets on the plain register port
`define OFS_CONTROL     3'h0
`define OFS_DIVIDER     3'h1
`define OFS_PERIOD      3'h2
`define OFS_COMPARE     3'h3
`define OFS_IRQ_STATUS  3'h4
`define OFS_IRQ_MASK    3'h5

// Control and compare register field positions
`define BIT_ENABLE      15
`define BIT_IDLE_STOP   13
`define BIT_PENDING     12
`define BIT_SE_IRQ_EN   11
`define BIT_IMM_UPDATE  10
`define BIT_SYNC_POL    9
`define BIT_SYNC_OEN    8
`define BIT_EXT_SYNC_EN 7
`define POS_SYNC_SRC    4
`define POS_POSTSCALE   0
`define POS_COMPARE     3

// Interrupt status bit positions
`define IRQ_SPECIAL     0
`define IRQ_PERIOD      1
`define IRQ_EXT_SYNC    2

// Reset values
`define RST_PERIOD      16'hfff8
`define RST_DIVIDER     3'h0

// Divider code that is reserved
`define DIV_RESERVED    3'h7
`endif

// *** pwm_tb_pkg.sv ***
package pwm_tb_pkg;

    // Sync source codes
    typedef enum logic [1:0] {
        SRC_INPUT_ONE,
        SRC_INPUT_TWO,
        SRC_RSVD_A,
        SRC_RSVD_B
    } sync_src_e;

    // Whole state of the master time base
    typedef struct packed {
        logic             module_enable;
        logic             idle_stop;
        logic             special_event_pending;
        logic             special_event_irq_enable;
        logic             immediate_period_update;
        logic             sync_polarity;
        logic             sync_output_enable;
        logic             external_sync_enable;
        logic [1:0]       sync_source_select;
        logic [3:0]       special_event_postscale;
        logic [2:0]       input_clock_divide_select;
        logic [15:0]      period_buffer;
        logic [15:0]      period_active;
        logic [12:0]      compare_value;
        logic [2:0]       irq_status;
        logic [2:0]       irq_mask;
        logic [5:0]       prescale_count;
        logic [15:0]      counter;
        logic [3:0]       postscale_count;
        logic [1:0]       sync_ff1;
        logic [1:0]       sync_ff2;
        logic [1:0]       sync_ff3;
        logic [1:0]       sync_stable;
        logic [15:0]      rdata;
        logic             irq;
        logic             trigger;
        logic             period_end;
        logic             sync_output;
        logic             sync_output_drive;
    } tb_state_s;

endpackage

// *** pwm_master_time_base.sv ***
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "pwm_tb_cfg.svh"

module pwm_master_time_base
    import pwm_tb_pkg::*;
#(
    parameter int CNT_WIDTH = 16  // Time base width
) (
    input  wire logic        clk_sys,                 // System clock
    input  wire logic        rst,                     // Async reset, high
    input  wire logic [2:0]  addr,                    // Register offset
    input  wire logic [15:0] wdata,                   // Write data
    input  wire logic        wr,                      // Write strobe
    input  wire logic        rd,                      // Read strobe
    output logic      [15:0] rdata,                   // Read data, next cycle
    output logic             irq,                     // Level interrupt
    input  wire logic        cpu_idle,                // CPU in Idle mode
    input  wire logic        sync_input_one,          // Sync pin one
    input  wire logic        sync_input_two,          // Sync pin two
    output logic             sync_output,             // Sync pin out
    output logic             sync_output_drive,       // Sync pin driven
    output logic      [15:0] master_time_base_counter, // Counter to generators
    output logic      [15:0] master_period,           // Active period out
    output logic             period_end,              // Period boundary pulse
    output logic             special_event_trigger,   // Trigger pulse
    output logic             special_event_pending    // Pending flag
);

    // Widths that the logic cannot serve are refused
    if (CNT_WIDTH != 16) begin : g_width_check
        $error("CNT_WIDTH must be 16");
    end

    // Reset image of the state
    localparam tb_state_s ST_RESET = '{
        period_buffer:             `RST_PERIOD,
        period_active:             `RST_PERIOD,
        input_clock_divide_select: `RST_DIVIDER,
        default:                   '0
    };

    tb_state_s st;       // Registered state
    tb_state_s next_st;  // Next state

    // Terminal prescale count for a divider code
    function automatic logic [5:0] div_limit(input logic [2:0] code);
        logic [5:0] lim;
        lim = 6'h00;
        case (code)
            3'h0:    lim = 6'h00;
            3'h1:    lim = 6'h01;
            3'h2:    lim = 6'h03;
            3'h3:    lim = 6'h07;
            3'h4:    lim = 6'h0f;
            3'h5:    lim = 6'h1f;
            3'h6:    lim = 6'h3f;
            default: lim = 6'h3f;
        endcase
        return lim;
    endfunction

    // Register read image of the current state
    function automatic logic [15:0] reg_image(input tb_state_s s, input logic [2:0] a);
        logic [15:0] v;
        v = 16'h0000;
        case (a)
            `OFS_CONTROL: begin
                v[`BIT_ENABLE]      = s.module_enable;
                v[`BIT_IDLE_STOP]   = s.idle_stop;
                v[`BIT_PENDING]     = s.special_event_pending;
                v[`BIT_SE_IRQ_EN]   = s.special_event_irq_enable;
                v[`BIT_IMM_UPDATE]  = s.immediate_period_update;
                v[`BIT_SYNC_POL]    = s.sync_polarity;
                v[`BIT_SYNC_OEN]    = s.sync_output_enable;
                v[`BIT_EXT_SYNC_EN] = s.external_sync_enable;
                v[`POS_SYNC_SRC+:2] = s.sync_source_select;
                v[`POS_POSTSCALE+:4] = s.special_event_postscale;
            end
            `OFS_DIVIDER:    v[2:0] = s.input_clock_divide_select;
            `OFS_PERIOD:     v = s.period_buffer;
            `OFS_COMPARE:    v[15:`POS_COMPARE] = s.compare_value;
            `OFS_IRQ_STATUS: v[2:0] = s.irq_status;
            `OFS_IRQ_MASK:   v[2:0] = s.irq_mask;
            default:         v = 16'h0000;
        endcase
        return v;
    endfunction

    // Decoded conditions of the current cycle
    logic        run;          // Time base advancing
    logic        tick;         // Prescaled clock tick
    logic [1:0]  sync_rise;    // Active edge per sync input
    logic        ext_sync;     // Selected external sync event
    logic        wrap;         // Counter reaching period
    logic        boundary;     // Period boundary
    logic        match;        // Compare match event
    logic        fire;         // Postscaled trigger
    logic        wr_ctl;       // Control write
    logic        wr_sts;       // Status write

    // Next state computation
    always_comb begin
        next_st = st;
        // Halt in Idle only when idle-stop is set
        run  = st.module_enable && !(st.idle_stop && cpu_idle);
        tick = run && (st.prescale_count == div_limit(st.input_clock_divide_select))
               && (st.input_clock_divide_select != `DIV_RESERVED);
        wr_ctl = wr && (addr == `OFS_CONTROL);
        wr_sts = wr && (addr == `OFS_IRQ_STATUS);

        // Three-stage synchronisers, level accepted when stages two and three agree
        next_st.sync_ff1 = {sync_input_two, sync_input_one};
        next_st.sync_ff2 = st.sync_ff1;
        next_st.sync_ff3 = st.sync_ff2;
        for (int i = 0; i < 2; i++) begin
            // Polarity folded in so active level is one
            if (st.sync_ff2[i] == st.sync_ff3[i]) begin
                next_st.sync_stable[i] = st.sync_ff3[i] ^ st.sync_polarity;
            end
            sync_rise[i] = next_st.sync_stable[i] && !st.sync_stable[i];
        end

        // Selected source, reserved codes select nothing
        case (sync_src_e'(st.sync_source_select))
            SRC_INPUT_ONE: ext_sync = sync_rise[0];
            SRC_INPUT_TWO: ext_sync = sync_rise[1];
            default:       ext_sync = 1'b0;
        endcase
        ext_sync = ext_sync && st.external_sync_enable && run;

        // Prescaler
        if (!run || tick) begin
            next_st.prescale_count = 6'h00;
        end else begin
            next_st.prescale_count = st.prescale_count + 6'h01;
        end

        // Counter wraps after the active period
        wrap     = tick && (st.counter >= st.period_active);
        boundary = wrap || ext_sync;
        match    = tick && (st.counter == {st.compare_value, 3'h0});
        if (!st.module_enable || ext_sync) begin
            next_st.counter = 16'h0000;
        end else if (wrap) begin
            next_st.counter = 16'h0000;
        end else if (tick) begin
            next_st.counter = st.counter + 16'h0001;
        end

        // Postscaler of compare matches
        fire = match && (st.postscale_count == st.special_event_postscale);
        if (!st.module_enable || fire) begin
            next_st.postscale_count = 4'h0;
        end else if (match) begin
            next_st.postscale_count = st.postscale_count + 4'h1;
        end

        // Register writes
        if (wr_ctl) begin
            next_st.module_enable            = wdata[`BIT_ENABLE];
            next_st.idle_stop                = wdata[`BIT_IDLE_STOP];
            next_st.special_event_irq_enable = wdata[`BIT_SE_IRQ_EN];
            next_st.immediate_period_update  = wdata[`BIT_IMM_UPDATE];
            next_st.sync_polarity            = wdata[`BIT_SYNC_POL];
            next_st.sync_output_enable       = wdata[`BIT_SYNC_OEN];
            next_st.external_sync_enable     = wdata[`BIT_EXT_SYNC_EN];
            next_st.sync_source_select       = wdata[`POS_SYNC_SRC+:2];
            next_st.special_event_postscale  = wdata[`POS_POSTSCALE+:4];
        end
        if (wr && addr == `OFS_DIVIDER) begin
            next_st.input_clock_divide_select = wdata[2:0];
        end
        if (wr && addr == `OFS_COMPARE) begin
            next_st.compare_value = wdata[15:`POS_COMPARE];
        end
        if (wr && addr == `OFS_IRQ_MASK) begin
            next_st.irq_mask = wdata[2:0];
        end
        if (wr && addr == `OFS_PERIOD) begin
            next_st.period_buffer = wdata;
        end

        // Active period: immediate, at boundary, or while stopped
        if (wr && addr == `OFS_PERIOD && st.immediate_period_update) begin
            next_st.period_active = wdata;
        end else if (boundary || !st.module_enable) begin
            next_st.period_active = next_st.period_buffer;
        end

        // Sticky status, write one clears, set wins
        if (wr_sts) begin
            next_st.irq_status = st.irq_status & ~wdata[2:0];
        end
        if (fire) begin
            next_st.irq_status[`IRQ_SPECIAL] = 1'b1;
        end
        if (boundary) begin
            next_st.irq_status[`IRQ_PERIOD] = 1'b1;
        end
        if (ext_sync) begin
            next_st.irq_status[`IRQ_EXT_SYNC] = 1'b1;
        end

        // Pending flag: cleared by hardware when disabled or acknowledged
        if (!next_st.special_event_irq_enable) begin
            next_st.special_event_pending = 1'b0;
        end else if (wr_sts && wdata[`IRQ_SPECIAL]) begin
            next_st.special_event_pending = 1'b0;
        end
        if (fire && next_st.special_event_irq_enable) begin
            next_st.special_event_pending = 1'b1;
        end

        // Outputs, all registered
        next_st.irq        = |(next_st.irq_status & next_st.irq_mask)
                             || next_st.special_event_pending;
        next_st.trigger    = fire;
        next_st.period_end = boundary;
        next_st.sync_output_drive = st.sync_output_enable;
        if (st.sync_output_enable) begin
            next_st.sync_output = boundary ^ st.sync_polarity;
        end else begin
            next_st.sync_output = 1'b0;
        end
        next_st.rdata = rd ? reg_image(st, addr) : 16'h0000;
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state
    assign rdata                    = st.rdata;
    assign irq                      = st.irq;
    assign sync_output              = st.sync_output;
    assign sync_output_drive        = st.sync_output_drive;
    assign master_time_base_counter = st.counter;
    assign master_period            = st.period_active;
    assign period_end               = st.period_end;
    assign special_event_trigger    = st.trigger;
    assign special_event_pending    = st.special_event_pending;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Disabled module holds the counter at zero
    a_disabled_count_zero: assert property (
        !st.module_enable |=> st.counter == 16'h0000)
        else $error("counter moved while disabled");

    // Idle with idle-stop freezes the counter
    a_idle_freezes: assert property (
        (st.module_enable && st.idle_stop && cpu_idle && !ext_sync)
        |=> $stable(st.counter))
        else $error("counter moved in idle stop");

    // Pending follows a trigger when enabled
    a_pending_on_fire: assert property (
        (fire && next_st.special_event_irq_enable) |=> special_event_pending)
        else $error("pending not set");

    // Pending cannot stand while its enable is low
    a_pending_needs_en: assert property (
        !st.special_event_irq_enable |-> !st.special_event_pending)
        else $error("pending without enable");

    // Immediate update reaches the active period next cycle
    a_immediate_period: assert property (
        (wr && addr == `OFS_PERIOD && st.immediate_period_update)
        |=> master_period == $past(wdata))
        else $error("immediate period missing");

    // Buffered period stays put away from boundaries
    a_period_held: assert property (
        (st.module_enable && !st.immediate_period_update && !boundary)
        |=> $stable(st.period_active))
        else $error("period changed mid cycle");

    // Disabled sync output stays low
    a_sync_out_off: assert property (
        !st.sync_output_enable |=> !sync_output && !sync_output_drive)
        else $error("sync output driven");

    // External sync clears the counter
    a_ext_sync_reset: assert property (
        ext_sync |=> st.counter == 16'h0000)
        else $error("sync did not reset counter");

    // Postscaler never passes its setting
    a_post_bound: assert property (
        st.postscale_count <= st.special_event_postscale || !$stable(st.special_event_postscale))
        else $error("postscale overrun");

    // Counter never passes the active period while enabled
    a_count_bound: assert property (
        (st.module_enable && $stable(st.period_active) && st.counter <= st.period_active
         && !(wr && addr == `OFS_PERIOD && st.immediate_period_update))
        |=> st.counter <= st.period_active)
        else $error("counter passed period");

    // Trigger pulse is one cycle long
    a_trig_pulse: assert property (
        special_event_trigger && !$past(ext_sync) |=> !special_event_trigger)
        else $error("trigger too long");

    // Reserved divider code stops the counter
    a_reserved_div_halt: assert property (
        (st.module_enable && st.input_clock_divide_select == `DIV_RESERVED && !ext_sync)
        |=> $stable(st.counter))
        else $error("counter moved on reserved divider");

    // Main scenarios
    c_wrap:    cover property (period_end);
    c_trigger: cover property (special_event_trigger ##[1:200] special_event_trigger);
    c_sync:    cover property (ext_sync);
    c_irq:     cover property (irq);

endmodule

// *** sync_pulse_source.sv ***
`timescale 1ns/100ps
// Far-side sync source: holds a pulse for WIDTH cycles on the requested pin
module sync_pulse_source #(
    parameter int WIDTH = 4  // Pulse length in cycles
) (
    input  wire logic clk_sys,        // System clock
    input  wire logic active_low,     // Pulse polarity
    input  wire logic fire_one,       // Start a pulse on pin one
    input  wire logic fire_two,       // Start a pulse on pin two
    output logic      sync_input_one, // Sync pin one
    output logic      sync_input_two  // Sync pin two
);
    int left_one = 0;  // Pulse cycles left on pin one
    int left_two = 0;  // Pulse cycles left on pin two

    // Count each pulse down; long enough to pass the input synchroniser
    always @(posedge clk_sys) begin
        left_one <= fire_one ? WIDTH : (left_one > 0 ? left_one - 1 : 0);
        left_two <= fire_two ? WIDTH : (left_two > 0 ? left_two - 1 : 0);
    end

    // Pins rest at the inactive level of the chosen polarity
    assign sync_input_one = (left_one > 0) ^ active_low;
    assign sync_input_two = (left_two > 0) ^ active_low;
endmodule

// *** pwm_master_time_base_tb.sv ***
`timescale 1ns/100ps
`include "pwm_tb_cfg.svh"
module pwm_master_time_base_tb;
    logic        clk_sys = 1'b0;  // System clock
    logic        rst = 1'b1;      // Reset
    logic        wr = 1'b0;       // Write strobe
    logic        rd = 1'b0;       // Read strobe
    logic        cpu_idle = 1'b0; // Idle indicator
    logic        fire_one = 1'b0; // Partner pulse request
    logic        fire_two = 1'b0; // Partner pulse request
    logic        active_low = 1'b0; // Partner polarity
    logic [2:0]  addr = 3'h0;     // Register offset
    logic [15:0] wdata = 16'h0000; // Write data
    logic [15:0] rdata, master_time_base_counter, master_period;
    logic        irq, sync_input_one, sync_input_two, sync_output, sync_output_drive;
    logic        period_end, special_event_trigger, special_event_pending;
    int          fails = 0;       // Mismatches
    int          tests_run = 0;   // Comparisons

    pwm_master_time_base i_pwm_master_time_base (.clk_sys(clk_sys), .rst(rst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
        .cpu_idle(cpu_idle), .sync_input_one(sync_input_one),
        .sync_input_two(sync_input_two), .sync_output(sync_output),
        .sync_output_drive(sync_output_drive),
        .master_time_base_counter(master_time_base_counter),
        .master_period(master_period), .period_end(period_end),
        .special_event_trigger(special_event_trigger),
        .special_event_pending(special_event_pending));
    sync_pulse_source i_sync_pulse_source (.clk_sys(clk_sys), .active_low(active_low),
        .fire_one(fire_one), .fire_two(fire_two), .sync_input_one(sync_input_one),
        .sync_input_two(sync_input_two));

    // Clock, 10 ns period
    always #5 clk_sys = ~clk_sys;

    // Compare one result and count it
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One-cycle register write
    task wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    // One-cycle register read; data stand in the following cycle only
    task rd_reg(input logic [2:0] a, output logic [15:0] q);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 q = rdata;
    endtask

    // Settings change only with the module stopped
    task setup(input logic [15:0] per, input logic [15:0] div, input logic [15:0] ctl);
        wr_reg(`OFS_CONTROL, 16'h0000);
        wr_reg(`OFS_PERIOD, per);
        wr_reg(`OFS_DIVIDER, div);
        wr_reg(`OFS_CONTROL, ctl);
    endtask

    // Selected pulse: period boundary or special event trigger
    function automatic logic pulse(input logic sel);
        return sel ? special_event_trigger : period_end;
    endfunction

    // Cycles from one pulse to the next; 0 when none arrives
    task between(input logic sel, output int n);
        int k;
        k = 0;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1 k++;
        end while (pulse(sel) !== 1'b1 && k < 2500);
        if (k < 2500) begin
            do begin
                @(posedge clk_sys);
                #1 n++;
            end while (pulse(sel) !== 1'b1 && n < 2500);
        end
    endtask

    // Reset values, read-only and unmapped places
    task t_regs;
        logic [15:0] q;
        chk("period out", 16'hfff8, master_period);
        rd_reg(`OFS_CONTROL, q); chk("control", 16'h0000, q);
        rd_reg(`OFS_PERIOD, q); chk("period", 16'hfff8, q);
        wr_reg(`OFS_CONTROL, 16'h7fff);
        rd_reg(`OFS_CONTROL, q); chk("control", 16'h2fbf, q);
        wr_reg(`OFS_DIVIDER, 16'hffff);
        rd_reg(`OFS_DIVIDER, q); chk("divider", 16'h0007, q);
        wr_reg(`OFS_COMPARE, 16'hffff);
        rd_reg(`OFS_COMPARE, q); chk("compare", 16'hfff8, q);
        wr_reg(3'h7, 16'hffff);
        rd_reg(3'h7, q); chk("unmapped", 16'h0000, q);
        $display("t_regs done");
    endtask

    // Every divider code, reserved one included
    task t_div;
        int n;
        for (int d = 0; d <= 7; d++) begin
            setup(16'h0010, 16'(d), 16'h8000);
            between(1'b0, n);
            chk("period gap", d == 7 ? 0 : 17 << d, n);
        end
        $display("t_div done");
    endtask

    // Disabled and idle-stopped counter holds
    task t_idle;
        logic [15:0] c;
        setup(16'h0100, 16'h0000, 16'h0000);
        c = master_time_base_counter;
        repeat (20) @(posedge clk_sys);
        #1 chk("disabled", c, master_time_base_counter);
        wr_reg(`OFS_CONTROL, 16'ha000);
        cpu_idle <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 c = master_time_base_counter;
        repeat (20) @(posedge clk_sys);
        #1 chk("idle halt", c, master_time_base_counter);
        wr_reg(`OFS_CONTROL, 16'h8000);
        repeat (3) @(posedge clk_sys);
        #1 c = master_time_base_counter;
        repeat (20) @(posedge clk_sys);
        #1 chk("idle run", c + 16'd20, master_time_base_counter);
        @(posedge clk_sys);
        cpu_idle <= 1'b0;
        $display("t_idle done");
    endtask

    // Postscaler ratios, pending flag and its enable
    task t_post;
        int n;
        int ps_tab[3] = '{0, 3, 15};
        wr_reg(`OFS_COMPARE, 16'h0008);
        foreach (ps_tab[i]) begin
            setup(16'h0010, 16'h0000, 16'h8800 | 16'(ps_tab[i]));
            between(1'b1, n);
            chk("trigger gap", 17 * (ps_tab[i] + 1), n);
            repeat (2) @(posedge clk_sys);
            #1 chk("pending", 1'b1, special_event_pending);
            chk("irq", 1'b1, irq);
        end
        setup(16'h0010, 16'h0000, 16'h8000);
        between(1'b1, n);
        repeat (2) @(posedge clk_sys);
        #1 chk("pending off", 1'b0, special_event_pending);
        $display("t_post done");
    endtask

    // Irq output after a settling delay
    task chk_irq(input logic exp);
        repeat (2) @(posedge clk_sys);
        #1 chk("irq", exp, irq);
    endtask

    // Status bits set, masked and cleared by writing ones
    task t_irq;
        logic [15:0] q;
        int n;
        setup(16'h0010, 16'h0000, 16'h0000);
        wr_reg(`OFS_IRQ_STATUS, 16'h0007);
        rd_reg(`OFS_IRQ_STATUS, q); chk("status", 16'h0000, q);
        wr_reg(`OFS_CONTROL, 16'h8000);
        between(1'b0, n);
        wr_reg(`OFS_CONTROL, 16'h0000);
        rd_reg(`OFS_IRQ_STATUS, q); chk("status", 16'h0003, q);
        chk_irq(1'b0);
        wr_reg(`OFS_IRQ_MASK, 16'h0002);
        chk_irq(1'b1);
        wr_reg(`OFS_IRQ_STATUS, 16'h0002);
        chk_irq(1'b0);
        rd_reg(`OFS_IRQ_STATUS, q); chk("status", 16'h0001, q);
        wr_reg(`OFS_IRQ_MASK, 16'h0001);
        chk_irq(1'b1);
        wr_reg(`OFS_IRQ_STATUS, 16'h0001);
        chk_irq(1'b0);
        $display("t_irq done");
    endtask

    // Sync output level, polarity and drive flag
    task t_sync_out;
        int n;
        logic [15:0] tab[3] = '{16'h8100, 16'h8300, 16'h8000};
        foreach (tab[i]) begin
            setup(16'h0010, 16'h0000, tab[i]);
            between(1'b0, n);
            chk("sync active", tab[i][8] & ~tab[i][9], sync_output);
            @(posedge clk_sys);
            #1 chk("sync idle", tab[i][8] & tab[i][9], sync_output);
            chk("sync drive", tab[i][8], sync_output_drive);
        end
        $display("t_sync_out done");
    endtask

    // External sync: source select, polarity and enable
    task t_ext;
        logic [15:0] mn;
        logic [15:0] q;
        logic [15:0] ctl[5] = '{16'h8080, 16'h8290, 16'h8080, 16'h80a0, 16'h8000};
        logic        pin[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        logic        hit[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        foreach (ctl[i]) begin
            @(posedge clk_sys);
            active_low <= ctl[i][9];
            setup(16'h0100, 16'h0000, ctl[i]);
            wr_reg(`OFS_IRQ_STATUS, 16'h0007);
            repeat (64) @(posedge clk_sys);
            fire_one <= ~pin[i];
            fire_two <= pin[i];
            @(posedge clk_sys);
            fire_one <= 1'b0;
            fire_two <= 1'b0;
            mn = 16'hffff;
            repeat (12) begin
                @(posedge clk_sys);
                #1 if (master_time_base_counter < mn) mn = master_time_base_counter;
            end
            chk("sync reset", hit[i], mn < 16'h0010);
            rd_reg(`OFS_IRQ_STATUS, q);
            chk("sync flag", hit[i], q[`IRQ_EXT_SYNC]);
        end
        $display("t_ext done");
    endtask

    // Period update at boundary versus at once
    task t_update;
        int n;
        setup(16'h0100, 16'h0000, 16'h8000);
        between(1'b0, n);
        wr_reg(`OFS_PERIOD, 16'h0080);
        repeat (2) @(posedge clk_sys);
        #1 chk("held period", 16'h0100, master_period);
        between(1'b0, n);
        chk("new gap", 16'h0081, n);
        setup(16'h0100, 16'h0000, 16'h8400);
        between(1'b0, n);
        wr_reg(`OFS_PERIOD, 16'h0040);
        repeat (2) @(posedge clk_sys);
        #1 chk("now period", 16'h0040, master_period);
        between(1'b0, n);
        chk("now gap", 16'h0041, n);
        $display("t_update done");
    endtask

    // Counts, verdict and end of run
    task wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs;
        t_div;
        t_idle;
        t_post;
        t_irq;
        t_sync_out;
        t_ext;
        t_update;
        wrap_up;
    end

    // Watchdog against a hang
    initial begin
        #500000;
        fails++;
        $display("watchdog expired");
        wrap_up;
    end
endmodule
